// >>> logic/ags_pkg.sv
/*
 * Constants and carrier types for the analog gain and offset scaler.
 * Assumes one 20 MHz system clock and an ADC code on that clock.
 */
package ags_pkg;
	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int RAW_W = 12;
	localparam int CNT_W = 10;
	localparam int GAIN_W = 11;
	localparam int OFFS_W = 15;
	localparam int PROD_W = 22;
	localparam int OUT_W = 16;
	// ------------------------------------------------------------
	// Ranges and scale
	// ------------------------------------------------------------
	localparam logic [CNT_W-1:0] COUNT_MIN = 10'h000;
	localparam logic [CNT_W-1:0] COUNT_MAX = 10'h3E8;
	localparam logic [RAW_W-1:0] FS_CODE_DEF = 12'hFA0;
	localparam logic signed [GAIN_W-1:0] GAIN_MAX = 11'sh3E8;
	localparam logic signed [GAIN_W-1:0] GAIN_MIN = -11'sh3E8;
	localparam logic signed [PROD_W-1:0] GAIN_SCALE = 22'sh000064;
	localparam logic signed [OFFS_W-1:0] OFFS_MAX = 15'sh2710;
	localparam logic signed [OFFS_W-1:0] OFFS_MIN = -15'sh2710;
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [CNT_W-1:0] COUNT_RST = 10'h000;
	localparam logic signed [OUT_W-1:0] VALUE_RST = 16'sh0000;
	localparam logic signed [GAIN_W-1:0] GAIN_RST = 11'sh000;
	localparam logic signed [OFFS_W-1:0] OFFS_RST = 15'sh0000;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic signed [GAIN_W-1:0] gain;
		logic signed [OFFS_W-1:0] offset;
	} ags_cfg_t;
	typedef struct packed {
		logic valid;
		logic signed [OUT_W-1:0] value;
	} ags_res_t;
endpackage : ags_pkg

// >>> logic/ags_norm.sv
/*
 * Converts a raw ADC code to the internal count, saturating at full scale.
 * Assumes the ADC code and its strobe are on sys_clk_in.
 */
`timescale 1ns/1ps
`default_nettype none
module ags_norm #(
	parameter int RAW_W = 12,
	parameter logic [RAW_W-1:0] FS_CODE = ags_pkg::FS_CODE_DEF
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Raw sample
	input wire logic raw_valid_in,
	input wire logic [RAW_W-1:0] raw_code_in,
	// Internal count
	output logic cnt_valid_out,
	output logic [ags_pkg::CNT_W-1:0] cnt_out
);
	import ags_pkg::*;
	logic [CNT_W-1:0] cnt_d, cnt_q;
	logic vld_d, vld_q;
	logic [31:0] lin;

	// ------------------------------------------------------------
	// Conversion
	// ------------------------------------------------------------
	always_comb begin
		lin = (32'(raw_code_in) * 32'(COUNT_MAX)) / 32'(FS_CODE);
		vld_d = raw_valid_in;
		cnt_d = cnt_q;
		if (raw_valid_in) begin
			if (raw_code_in >= FS_CODE) begin
				cnt_d = COUNT_MAX;
			end else begin
				cnt_d = CNT_W'(lin);
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_q <= COUNT_RST;
			vld_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			vld_q <= vld_d;
		end
	end

	assign cnt_out = cnt_q;
	assign cnt_valid_out = vld_q;
endmodule : ags_norm
`default_nettype wire

// >>> logic/ags_scaler.sv
/*
 * Analog gain and offset scaler: count, multiply by gain, add offset.
 * Assumes ADC code and configuration come from logic on sys_clk_in.
 */
// Overview of operation
// - Every sample becomes an unsigned count from 0 to 1000 first.
// - Zero to full-scale input maps linearly onto counts 0 to 1000.
// - Input above full scale holds the count at 1000.
// - Result is count times gain, then plus offset.
// - Gain is signed hundredths, limited to -10.00 to +10.00.
// - Offset is a signed integer limited to -10000 to +10000.
`timescale 1ns/1ps
`default_nettype none
module ags_scaler #(
	parameter int RAW_W = ags_pkg::RAW_W,
	parameter logic [RAW_W-1:0] FS_CODE = ags_pkg::FS_CODE_DEF
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Analog input terminal sample
	input wire logic sample_valid_in,
	input wire logic [RAW_W-1:0] sample_code_in,
	// Configuration
	input wire ags_pkg::ags_cfg_t cfg_in,
	// Results
	output logic count_valid_out,
	output logic [ags_pkg::CNT_W-1:0] count_out,
	output ags_pkg::ags_res_t scaled_analog_value_out
);
	import ags_pkg::*;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic signed [GAIN_W-1:0] clamp_gain(
		input logic signed [GAIN_W-1:0] g);
		logic signed [GAIN_W-1:0] r;
		r = g;
		if (g > GAIN_MAX) begin
			r = GAIN_MAX;
		end else if (g < GAIN_MIN) begin
			r = GAIN_MIN;
		end
		return r;
	endfunction : clamp_gain

	function automatic logic signed [OFFS_W-1:0] clamp_offs(
		input logic signed [OFFS_W-1:0] o);
		logic signed [OFFS_W-1:0] r;
		r = o;
		if (o > OFFS_MAX) begin
			r = OFFS_MAX;
		end else if (o < OFFS_MIN) begin
			r = OFFS_MIN;
		end
		return r;
	endfunction : clamp_offs

	function automatic logic signed [OUT_W-1:0] scale_trunc(
		input logic [CNT_W-1:0] c,
		input logic signed [GAIN_W-1:0] g);
		logic signed [PROD_W-1:0] p;
		p = PROD_W'($signed({1'b0, c}) * g);
		return OUT_W'(p / GAIN_SCALE);
	endfunction : scale_trunc

	// ------------------------------------------------------------
	// Count stage
	// ------------------------------------------------------------
	logic cnt_vld;
	logic [CNT_W-1:0] cnt;

	ags_norm #(
		.RAW_W(RAW_W),
		.FS_CODE(FS_CODE)
	) u_norm (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.raw_valid_in(sample_valid_in),
		.raw_code_in(sample_code_in),
		.cnt_valid_out(cnt_vld),
		.cnt_out(cnt)
	);

	// ------------------------------------------------------------
	// Configuration stage
	// ------------------------------------------------------------
	ags_cfg_t cfg_d, cfg_q;

	always_comb begin
		cfg_d.gain = clamp_gain(cfg_in.gain);
		cfg_d.offset = clamp_offs(cfg_in.offset);
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg_q <= '{gain: GAIN_RST, offset: OFFS_RST};
		end else begin
			cfg_q <= cfg_d;
		end
	end

	// ------------------------------------------------------------
	// Multiply stage
	// ------------------------------------------------------------
	logic scl_vld_d, scl_vld_q;
	logic signed [OUT_W-1:0] scl_d, scl_q;
	logic signed [OFFS_W-1:0] offs_d, offs_q;

	always_comb begin
		scl_vld_d = cnt_vld;
		scl_d = scl_q;
		offs_d = offs_q;
		if (cnt_vld) begin
			scl_d = scale_trunc(cnt, cfg_q.gain);
			offs_d = cfg_q.offset;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			scl_vld_q <= 1'b0;
			scl_q <= VALUE_RST;
			offs_q <= OFFS_RST;
		end else begin
			scl_vld_q <= scl_vld_d;
			scl_q <= scl_d;
			offs_q <= offs_d;
		end
	end

	// ------------------------------------------------------------
	// Offset stage
	// ------------------------------------------------------------
	ags_res_t res_d, res_q;

	always_comb begin
		res_d.valid = scl_vld_q;
		res_d.value = res_q.value;
		if (scl_vld_q) begin
			res_d.value = scl_q + OUT_W'(offs_q);
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			res_q <= '{valid: 1'b0, value: VALUE_RST};
		end else begin
			res_q <= res_d;
		end
	end

	assign count_valid_out = cnt_vld;
	assign count_out = cnt;
	assign scaled_analog_value_out = res_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);

	property p_cnt_range;
		cnt_vld |-> cnt <= COUNT_MAX;
	endproperty
	a_cnt_range: assert property (p_cnt_range)
		else $error("count above 1000");

	property p_zero_in;
		sample_valid_in && sample_code_in == '0 |=> cnt_vld && cnt == COUNT_MIN;
	endproperty
	a_zero_in: assert property (p_zero_in)
		else $error("zero input not count zero");

	property p_sat;
		sample_valid_in && sample_code_in >= FS_CODE |=> cnt == COUNT_MAX;
	endproperty
	a_sat: assert property (p_sat)
		else $error("over-range input not saturated");

	property p_mul_add;
		cnt_vld |-> ##2 scaled_analog_value_out.valid &&
			scaled_analog_value_out.value ==
			scale_trunc($past(cnt, 2), $past(cfg_q.gain, 2)) +
			OUT_W'($past(cfg_q.offset, 2));
	endproperty
	a_mul_add: assert property (p_mul_add)
		else $error("scaled value mismatch");

	property p_gain_lim;
		cfg_q.gain <= GAIN_MAX && cfg_q.gain >= GAIN_MIN;
	endproperty
	a_gain_lim: assert property (p_gain_lim)
		else $error("gain out of range");

	property p_offs_lim;
		##1 (cfg_in.offset > OFFS_MAX) |=> cfg_q.offset == OFFS_MAX;
	endproperty
	a_offs_lim: assert property (p_offs_lim)
		else $error("offset not limited");

	property p_gain_hi;
		cfg_in.gain > GAIN_MAX |=> cfg_q.gain == GAIN_MAX;
	endproperty
	a_gain_hi: assert property (p_gain_hi)
		else $error("gain not limited high");

	property p_offs_lo;
		cfg_in.offset < OFFS_MIN |=> cfg_q.offset == OFFS_MIN;
	endproperty
	a_offs_lo: assert property (p_offs_lo)
		else $error("offset not limited low");

	property p_trunc;
		cnt_vld && cnt == 10'h002 && cfg_q.gain == 11'sh00A |=> scl_q == '0;
	endproperty
	a_trunc: assert property (p_trunc)
		else $error("fraction not discarded");

	property p_latency;
		sample_valid_in |-> ##3 scaled_analog_value_out.valid;
	endproperty
	a_latency: assert property (p_latency)
		else $error("result not three cycles after sample");

	c_full: cover property (cnt_vld && cnt == COUNT_MAX);
	c_neg: cover property (scaled_analog_value_out.valid &&
		scaled_analog_value_out.value < 0);
	c_burst: cover property (sample_valid_in [*3]);
	c_clip: cover property (cfg_in.offset < OFFS_MIN);
endmodule : ags_scaler
`default_nettype wire

// >>> testbench/ags_sensor_model.sv
/*
 * Behavioural sensor plus converter feeding the scaler.
 * Assumes the bench drives mv_in and req_in on the falling edge.
 */
`timescale 1ns/1ps
`default_nettype none
module ags_sensor_model #(
	parameter int FS = 4000
) (
	// Stimulus from bench
	input wire logic req_in,
	input wire logic [15:0] mv_in,
	// Converter side
	output logic valid_out,
	output logic [11:0] code_out
);
	int conv;
	always_comb begin
		conv = int'(mv_in) * FS / 10000;
		if (conv > 4095) begin
			conv = 4095;
		end
		valid_out = req_in;
		// Idle code is scrambled, never left stale
		code_out = req_in ? conv[11:0] : ~conv[11:0];
	end
endmodule : ags_sensor_model
`default_nettype wire

// >>> testbench/test_analog_gain_offset_scaler.sv
/*
 * Self-checking bench for the gain and offset scaler.
 * Assumes the bench and the scaler share one 20 MHz clock; the sensor model is combinational.
 */
`timescale 1ns/1ps
`default_nettype none
module test_analog_gain_offset_scaler;
	import ags_pkg::*;
	localparam int FS = 4000;
	logic sys_clk;
	logic rst_n;
	logic req_q;
	logic [15:0] mv_q;
	ags_cfg_t cfg;
	logic s_valid;
	logic [11:0] s_code;
	logic count_valid_out;
	logic [CNT_W-1:0] count_out;
	ags_res_t res;
	int mismatches = 0;
	int total_checks = 0;
	ags_sensor_model #(.FS(FS)) ags_sensor_model_inst (
		.req_in(req_q), .mv_in(mv_q), .valid_out(s_valid), .code_out(s_code));
	ags_scaler #(.FS_CODE(12'(FS))) ags_scaler_inst (
		.sys_clk_in(sys_clk), .rst_n_in(rst_n), .sample_valid_in(s_valid),
		.sample_code_in(s_code), .cfg_in(cfg), .count_valid_out(count_valid_out),
		.count_out(count_out), .scaled_analog_value_out(res));
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic end_of_test();
		if (mismatches == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic signed [31:0] e,
		input logic signed [31:0] s);
		total_checks++;
		if (s !== e) begin
			$display("Error %s expected %0d seen %0d", nm, e, s);
			mismatches++;
		end
	endtask : chk
	task automatic wait_res(input int lim);
		int n;
		n = 0;
		while (res.valid !== 1'b1 && n < lim) begin
			@(negedge sys_clk);
			n++;
		end
		chk("value_valid", 1, n < lim);
	endtask : wait_res
	task automatic sample(input int mv, g, o, ec, ev);
		int n;
		cfg.gain = g[10:0];
		cfg.offset = o[14:0];
		repeat (2) @(negedge sys_clk);
		mv_q = mv[15:0];
		req_q = 1'b1;
		@(negedge sys_clk);
		req_q = 1'b0;
		n = 0;
		while (count_valid_out !== 1'b1 && n < 5) begin
			@(negedge sys_clk);
			n++;
		end
		chk("count_valid", 1, n < 5);
		chk("count", ec, count_out);
		wait_res(5);
		chk("value", ev, res.value);
	endtask : sample
	task automatic t_window();
		int tv [11][5] = '{'{0, 10, -30, 0, -30}, '{3000, 10, -30, 300, 0},
			'{10000, 10, -30, 1000, 70}, '{6750, 400, 1000, 675, 3700},
			'{5000, 1, 5, 500, 10}, '{10000, 1000, -10000, 1000, 0},
			'{20, 10, 0, 2, 0}, '{20, 1000, 0, 2, 20}, '{150, -10, 0, 15, -1},
			'{5000, 100, -200, 500, 300}, '{10000, -1000, -10000, 1000, -20000}};
		foreach (tv[i]) begin
			sample(tv[i][0], tv[i][1], tv[i][2], tv[i][3], tv[i][4]);
		end
	endtask : t_window
	task automatic t_saturate();
		sample(12000, 100, 0, 1000, 1000);
		sample(65000, 100, 7, 1000, 1007);
		sample(9990, 100, 0, 999, 999);
	endtask : t_saturate
	task automatic t_clamp();
		sample(10000, 1023, 16383, 1000, 20000);
		sample(10000, -1024, -16384, 1000, -20000);
	endtask : t_clamp
	task automatic t_derive();
		int lo;
		int hi;
		lo = 0;
		hi = 2000;
		sample(2500, (hi - lo) * 100 / 1000, lo, 250, 500);
	endtask : t_derive
	task automatic t_pipeline();
		cfg.gain = 11'sh064;
		cfg.offset = 15'sh0000;
		repeat (2) @(negedge sys_clk);
		mv_q = 16'd1000;
		req_q = 1'b1;
		@(negedge sys_clk);
		mv_q = 16'd9990;
		@(negedge sys_clk);
		req_q = 1'b0;
		wait_res(8);
		chk("pipe_first", 100, res.value);
		@(negedge sys_clk);
		chk("pipe_valid", 1, res.valid);
		chk("pipe_second", 999, res.value);
	endtask : t_pipeline
	initial begin
		#(3000 * 50);
		mismatches++;
		end_of_test();
	end
	initial begin
		rst_n = 1'b0;
		req_q = 1'b0;
		mv_q = 16'h0000;
		cfg = '0;
		repeat (5) @(posedge sys_clk);
		@(negedge sys_clk);
		rst_n = 1'b1;
		chk("reset_count", 0, count_out);
		chk("reset_value", 0, res.value);
		t_window();
		t_saturate();
		t_clamp();
		t_derive();
		t_pipeline();
		end_of_test();
	end
endmodule : test_analog_gain_offset_scaler
`default_nettype wire
